// >>> include/network_performance_report_pkg.sv
`default_nettype none
package network_performance_report_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_THRESH = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_REPORT = 8'h0C;
    localparam logic [7:0] ADDR_SENT = 8'h10;
    localparam logic [7:0] ADDR_DROP = 8'h14;
    localparam logic [7:0] ADDR_COUNTS = 8'h18;
    // Control fields and reset values
    localparam int CTRL_FS_MON = 0;
    localparam int CTRL_CUST = 1;
    localparam int CTRL_EN = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
    localparam logic [31:0] THRESH_RESET = 32'h0140_0140;
    // Frame constants
    localparam logic [7:0] FLAG_OCT = 8'h7E;
    localparam logic [7:0] SAPI_OCT = 8'h42;
    localparam logic [7:0] TEI_OCT = 8'h01;
    localparam logic [7:0] CTRL_OCT = 8'h03;
    localparam int FRAME_OCTETS = 11;
    localparam int HIST = 4;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    // Count bands
    localparam int COUNT_W = 10;
    localparam logic [9:0] BAND_LOW_MAX = 10'd100;
    localparam logic [9:0] BAND_MID_MAX = 10'd319;
    localparam logic [9:0] SF_MID_MAX_FT = 10'd3;
    localparam logic [9:0] SF_MID_MAX_FTFS = 10'd7;

    typedef struct packed {
        logic near_crc;
        logic near_fe;
        logic far_crc;
        logic near_sef;
        logic far_sef;
    } err_events_s;

    typedef struct packed {
        logic [7:0] odd;
        logic [7:0] even;
    } report_s;
endpackage
`default_nettype wire

// >>> verilog/report_encoder.sv
`default_nettype none
module report_encoder
    import network_performance_report_pkg::*;
(
    // Completed second
    input wire logic [COUNT_W-1:0] near_crc_cnt,
    input wire logic [COUNT_W-1:0] near_fe_cnt,
    input wire logic [COUNT_W-1:0] far_crc_cnt,
    input wire logic near_sef,
    input wire logic far_sef,
    input wire logic perf_alert,
    // Mode
    input wire logic sf_mode,
    input wire logic fs_monitored,
    input wire logic [1:0] report_counter,
    // Encoded pair
    output report_s report
);
    // Returns {high, mid, low, single}
    function automatic logic [3:0] crc_band(input logic [COUNT_W-1:0] c);
        crc_band[0] = (c == 10'd1);
        crc_band[1] = (c > 10'd1) && (c <= BAND_LOW_MAX);
        crc_band[2] = (c > BAND_LOW_MAX) && (c <= BAND_MID_MAX);
        crc_band[3] = (c > BAND_MID_MAX);
    endfunction

    logic [3:0] nb, fb, sfb;
    logic [COUNT_W-1:0] sf_max;

    always_comb begin
        sf_max = fs_monitored ? SF_MID_MAX_FTFS : SF_MID_MAX_FT;
        sfb[0] = (near_fe_cnt == 10'd1);
        sfb[1] = 1'b0;
        sfb[2] = (near_fe_cnt > 10'd1) && (near_fe_cnt <= sf_max);
        sfb[3] = (near_fe_cnt > sf_max);
        nb = sf_mode ? sfb : crc_band(near_crc_cnt);
        fb = crc_band(far_crc_cnt);
        report.odd = {nb[0], nb[1], near_sef, 1'b0,
                      nb[2], nb[3], perf_alert, sf_mode};
        report.even = {fb[0], fb[1], far_sef, 1'b0,
                       fb[2], fb[3], report_counter};
    end
endmodule
`default_nettype wire

// >>> verilog/hdlc_tx.sv
`default_nettype none
module hdlc_tx
    import network_performance_report_pkg::*;
#(
    parameter int N_OCT = FRAME_OCTETS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Frame request
    input wire logic start,
    input wire logic [N_OCT*8-1:0] payload,
    // Link bit slots
    input wire logic slot,
    output logic tx_bit,
    output logic active,
    output logic done
);
    typedef enum logic [2:0] {IDLE, OPEN, BODY, FCS, CLOSE} tx_state_e;
    localparam int IW = $clog2(N_OCT * 8);
    localparam logic [IW-1:0] BODY_LAST = IW'(N_OCT * 8 - 1);

    tx_state_e st_r;
    logic [IW-1:0] idx_r;
    logic [2:0] ones_r;
    logic [15:0] crc_r;
    logic [N_OCT*8-1:0] frame_r;
    logic stuff, b;

    assign stuff = (ones_r == STUFF_RUN);
    // Check octets go out complement-first-bit order of the CRC register
    assign b = (st_r == FCS) ? ~crc_r[idx_r[3:0]] : frame_r[idx_r];
    assign active = (st_r != IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= IDLE;
            idx_r <= '0;
            ones_r <= '0;
            crc_r <= CRC_INIT;
            frame_r <= '0;
            tx_bit <= 1'b1;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (st_r == IDLE && start) begin
                frame_r <= payload; // Frozen while it goes out
                st_r <= OPEN;
                idx_r <= '0;
            end else if (slot) begin
                case (st_r)
                    OPEN, CLOSE: begin
                        if (st_r == CLOSE && stuff) begin
                            tx_bit <= 1'b0;
                            ones_r <= '0;
                        end else begin
                            tx_bit <= FLAG_OCT[idx_r[2:0]];
                            idx_r <= (idx_r[2:0] == 3'h7) ? '0 : idx_r + 1'b1;
                            if (idx_r[2:0] == 3'h7) begin
                                st_r <= (st_r == OPEN) ? BODY : IDLE;
                                done <= (st_r == CLOSE);
                                crc_r <= CRC_INIT;
                                ones_r <= '0;
                            end
                        end
                    end
                    BODY, FCS: begin
                        if (stuff) begin
                            tx_bit <= 1'b0;
                            ones_r <= '0;
                        end else begin
                            tx_bit <= b;
                            ones_r <= b ? ones_r + 3'h1 : 3'h0;
                            if (st_r == BODY) begin
                                crc_r <= (crc_r >> 1) ^
                                    ((crc_r[0] ^ b) ? CRC_POLY : 16'h0000);
                            end
                            if (st_r == BODY && idx_r == BODY_LAST) begin
                                st_r <= FCS;
                                idx_r <= '0;
                            end else if (st_r == FCS && idx_r == IW'(15)) begin
                                st_r <= CLOSE;
                                idx_r <= '0;
                            end else begin
                                idx_r <= idx_r + 1'b1;
                            end
                        end
                    end
                    IDLE: begin
                        // Last flag bit is a zero; return the line to idle
                        tx_bit <= 1'b1;
                    end
                    default: st_r <= IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/network_performance_report_framer.sv
// Our own choices: the register addresses and register access over APB.
`default_nettype none
module network_performance_report_framer
    import network_performance_report_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Line events and framing state
    input wire err_events_s ev,
    input wire logic ci_sf_framing,
    input wire logic second_tick,
    // Customer report channel
    input wire logic cust_report_done,
    input wire logic [1:0] cust_report_count,
    // Data link
    input wire logic dl_slot,
    input wire logic dl_busy,
    output logic dl_bit,
    output logic dl_drive
);
    logic [31:0] ctrl_r;
    logic [31:0] thresh_r;
    logic [COUNT_W-1:0] near_crc_r, near_fe_r, far_crc_r;
    logic near_sef_r, far_sef_r;
    logic [COUNT_W-1:0] last_near_r, last_far_r;
    logic [1:0] cnt_r, cust_cnt_r, cnt_use;
    report_s hist_r [HIST];
    logic pending_r;
    logic [15:0] sent_r, drop_r;
    logic [31:0] prdata_r;
    logic [COUNT_W-1:0] near_sel;
    logic perf_alert;
    report_s enc;
    logic cust_mode, trigger, start_tx;
    logic tx_active, tx_done;
    logic [FRAME_OCTETS*8-1:0] payload;
    logic [7:0] octets [FRAME_OCTETS];
    logic wr_en, setup;

    // Saturate rather than wrap so a storm still lands in the top band
    function automatic logic [COUNT_W-1:0] sat_inc(
        input logic [COUNT_W-1:0] c, input logic e);
        sat_inc = (e && c != '1) ? c + 1'b1 : c;
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        case (a)
            ADDR_CTRL, ADDR_THRESH, ADDR_STATUS, ADDR_REPORT,
            ADDR_SENT, ADDR_DROP, ADDR_COUNTS: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction

    assign cust_mode = ctrl_r[CTRL_CUST];

    // APB: zero wait states, error on unmapped offsets
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && reg_hit(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !reg_hit(paddr);
    assign prdata = prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RESET;
            thresh_r <= THRESH_RESET;
        end else if (wr_en) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_r <= {29'h0, pwdata[2:0]};
            end
            if (paddr == ADDR_THRESH) begin
                thresh_r <= pwdata;
            end
        end
    end

    // Read data is captured in the setup phase so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            case (paddr)
                ADDR_CTRL: prdata_r <= ctrl_r;
                ADDR_THRESH: prdata_r <= thresh_r;
                ADDR_STATUS: prdata_r <= {26'h0, ci_sf_framing, tx_active,
                                          pending_r, 1'b0, cnt_use};
                ADDR_REPORT: prdata_r <= {16'h0, hist_r[0]};
                ADDR_SENT: prdata_r <= {16'h0, sent_r};
                ADDR_DROP: prdata_r <= {16'h0, drop_r};
                ADDR_COUNTS: prdata_r <= {6'h0, last_far_r,
                                          6'h0, last_near_r};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Per-second counting; an event in the boundary cycle opens the new
    // second instead of being lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            near_crc_r <= '0;
            near_fe_r <= '0;
            far_crc_r <= '0;
            near_sef_r <= 1'b0;
            far_sef_r <= 1'b0;
        end else if (second_tick) begin
            near_crc_r <= COUNT_W'(ev.near_crc);
            near_fe_r <= COUNT_W'(ev.near_fe);
            far_crc_r <= COUNT_W'(ev.far_crc);
            near_sef_r <= ev.near_sef;
            far_sef_r <= ev.far_sef;
        end else begin
            near_crc_r <= sat_inc(near_crc_r, ev.near_crc);
            near_fe_r <= sat_inc(near_fe_r, ev.near_fe);
            far_crc_r <= sat_inc(far_crc_r, ev.far_crc);
            near_sef_r <= near_sef_r | ev.near_sef;
            far_sef_r <= far_sef_r | ev.far_sef;
        end
    end

    // Alert compares the near count in use and the far count
    always_comb begin
        near_sel = ci_sf_framing ? near_fe_r : near_crc_r;
        perf_alert = (near_sel > thresh_r[COUNT_W-1:0]) ||
                     (far_crc_r > thresh_r[16 +: COUNT_W]);
    end

    // Report counter follows the customer's count when CTRL_CUST is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 2'h0;
            cust_cnt_r <= 2'h0;
        end else begin
            if (cust_report_done) begin
                cust_cnt_r <= cust_report_count;
            end
            if (second_tick) begin
                cnt_r <= cnt_use + 2'h1;
            end
        end
    end
    assign cnt_use = cust_mode ? cust_cnt_r : cnt_r;

    report_encoder u_enc (
        .near_crc_cnt(near_crc_r),
        .near_fe_cnt(near_fe_r),
        .far_crc_cnt(far_crc_r),
        .near_sef(near_sef_r),
        .far_sef(far_sef_r),
        .perf_alert(perf_alert),
        .sf_mode(ci_sf_framing),
        .fs_monitored(ctrl_r[CTRL_FS_MON]),
        .report_counter(cnt_use),
        .report(enc)
    );

    // Four-second history, newest at index 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < HIST; i++) begin
                hist_r[i] <= '0;
            end
            last_near_r <= '0;
            last_far_r <= '0;
        end else if (second_tick) begin
            hist_r[0] <= enc;
            for (int i = 1; i < HIST; i++) begin
                hist_r[i] <= hist_r[i-1];
            end
            last_near_r <= near_sel;
            last_far_r <= far_crc_r;
        end
    end

    // Frame contents between the flags, first octet in the low bits
    assign octets[0] = SAPI_OCT;
    assign octets[1] = TEI_OCT;
    assign octets[2] = CTRL_OCT;
    genvar g;
    generate
        for (g = 0; g < HIST; g++) begin : g_pair
            assign octets[3 + 2*g] = hist_r[g].odd;
            assign octets[4 + 2*g] = hist_r[g].even;
        end
        for (g = 0; g < FRAME_OCTETS; g++) begin : g_flat
            assign payload[g*8 +: 8] = octets[g];
        end
    endgenerate

    // One message per interval: the customer report in that mode, the
    // second tick otherwise. A message still waiting when the next
    // interval opens is dropped; once on the wire it always completes.
    assign trigger = cust_mode ? cust_report_done : second_tick;
    assign start_tx = pending_r && dl_slot && !dl_busy && !tx_active &&
                      ctrl_r[CTRL_EN];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_r <= 1'b0;
            drop_r <= 16'h0000;
        end else begin
            if (trigger && ctrl_r[CTRL_EN]) begin
                pending_r <= 1'b1;
            end else if (start_tx) begin
                pending_r <= 1'b0;
            end
            if (trigger && pending_r && !start_tx && drop_r != 16'hFFFF) begin
                drop_r <= drop_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sent_r <= 16'h0000;
        end else if (tx_done && sent_r != 16'hFFFF) begin
            sent_r <= sent_r + 16'h0001;
        end
    end

    // Our opening flag trails the customer's closing flag, so the
    // separation of at least one flag holds by construction
    hdlc_tx #(
        .N_OCT(FRAME_OCTETS)
    ) u_tx (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_tx),
        .payload(payload),
        .slot(dl_slot),
        .tx_bit(dl_bit),
        .active(tx_active),
        .done(tx_done)
    );

    assign dl_drive = tx_active;
endmodule
`default_nettype wire

// >>> bench/network_performance_report_checker.sv
`default_nettype none
module network_performance_report_checker
    import network_performance_report_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Data link
    input wire logic dl_slot,
    input wire logic dl_busy,
    input wire logic dl_bit,
    input wire logic dl_drive
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic slot_d;
    logic [3:0] run;
    // Flags give six ones in a row; stuffing keeps data at five or fewer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_d <= 1'b0;
            run <= 4'h0;
        end else begin
            slot_d <= dl_slot;
            if (!dl_drive)
                run <= 4'h0;
            else if (slot_d)
                run <= dl_bit ? run + 4'h1 : 4'h0;
        end
    end

    ones_run_a: assert property (run <= 4'h6)
        else $error("more than six ones in a row on the link");
    idle_one_a: assert property (!dl_drive && !$past(dl_drive) &&
        $past(dl_slot) |-> dl_bit) else $error("link not idle at one");
    bit_slot_a: assert property ($changed(dl_bit) |-> $past(dl_slot))
        else $error("link bit moved outside a slot");
    start_free_a: assert property ($rose(dl_drive) |->
        $past(dl_slot) && !$past(dl_busy)) else $error("frame began badly");
    frame_len_a: assert property ($rose(dl_drive) |=> dl_drive [*8])
        else $error("frame cut short");
    ready_hi_a: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    err_map_a: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
        else $error("unmapped access not refused");
    no_err_a: assert property (psel && penable && paddr <= 8'h18 &&
        paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
    rd_zero_a: assert property (psel && !penable && !pwrite &&
        paddr > 8'h18 |=> prdata == 32'h0) else $error("unmapped read data");
endmodule

bind network_performance_report_framer network_performance_report_checker chk_u (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dl_slot(dl_slot),
    .dl_busy(dl_busy), .dl_bit(dl_bit), .dl_drive(dl_drive));
`default_nettype wire

// >>> bench/dl_link_model.sv
`default_nettype none
module dl_link_model
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic dl_bit,
    input wire logic dl_drive,
    output logic dl_slot,
    output logic dl_busy,
    // Bench
    input wire logic hold,
    output int nframes,
    output logic [103:0] frame
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div;
    logic slot_d;
    logic [7:0] sh;
    logic [135:0] dq;
    int ones;
    int nb;
    // Slot every fourth clock keeps a frame to a few hundred cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 2'h0;
            dl_slot <= 1'b0;
            slot_d <= 1'b0;
            dl_busy <= 1'b0;
        end else begin
            div <= div + 2'h1;
            dl_slot <= div == 2'h3;
            slot_d <= dl_slot;
            dl_busy <= hold;
        end
    end
    // Hunt flags and drop stuffed zeros; only whole frames are kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh <= 8'hFF;
            ones <= 0;
            nb <= 0;
            nframes <= 0;
        end else if (slot_d) begin
            sh <= {dl_bit, sh[7:1]};
            ones <= dl_bit ? ones + 1 : 0;
            if ({dl_bit, sh[7:1]} == 8'h7E) begin
                nb <= 0;
                if (nb == 111) begin
                    frame <= dq[103:0];
                    nframes <= nframes + 1;
                end
            end else if (ones != 5 || dl_bit) begin
                dq[nb] <= dl_bit;
                nb <= nb + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`default_nettype none
module tb_top
    import network_performance_report_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0;
    logic presetn = 0;
    logic [7:0] paddr = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic pready, pslverr, rerr;
    err_events_s ev = '0;
    logic sf = 0, tick = 0, cdone = 0, hold = 0, first = 1;
    logic [1:0] ccnt = 0, cnt;
    logic dl_slot, dl_busy, dl_bit, dl_drive;
    logic [15:0] exp_q[$];
    logic [103:0] frame;
    int nframes, errors = 0, n_compared = 0, cyc = 0;

    always #25 pclk = ~pclk;

    network_performance_report_framer dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ev(ev),
        .ci_sf_framing(sf), .second_tick(tick), .cust_report_done(cdone),
        .cust_report_count(ccnt), .dl_slot(dl_slot), .dl_busy(dl_busy),
        .dl_bit(dl_bit), .dl_drive(dl_drive));
    dl_link_model link_u (.pclk(pclk), .presetn(presetn), .dl_bit(dl_bit),
        .dl_drive(dl_drive), .dl_slot(dl_slot), .dl_busy(dl_busy),
        .hold(hold), .nframes(nframes), .frame(frame));

    task summarize;
        if (errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] bnd(input int n, input logic s,
            input logic fs);
        if (n == 0) return 8'h00;
        if (n == 1) return 8'h80;
        if (s) return (n <= (fs ? 7 : 3)) ? 8'h08 : 8'h04;
        if (n <= 100) return 8'h40;
        return (n <= 319) ? 8'h08 : 8'h04;
    endfunction

    function automatic logic [15:0] residue(input logic [103:0] f);
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 104; i++)
            c = (c[0] ^ f[i]) ? (c >> 1) ^ CRC_POLY : c >> 1;
        return c;
    endfunction

    // One second of events, the tick, then the latched report
    task second(input int nn, input int nf, input logic fs);
        logic [7:0] od, evn;
        for (int i = 0; i < (nn > nf ? nn : nf); i++) begin
            @(posedge pclk);
            ev <= '{i < nn, i < nn, i < nf, nn == 2, nn == 2};
        end
        @(posedge pclk);
        ev <= '0;
        tick <= 1'b1;
        @(posedge pclk);
        tick <= 1'b0;
        apb(ADDR_REPORT, 1'b0, 32'h0);
        od = bnd(nn, sf, fs) | (nn == 2 ? 8'h20 : 8'h00) | {6'h0, nn > 100, sf};
        evn = bnd(nf, 1'b0, 1'b0) | (nn == 2 ? 8'h20 : 8'h00);
        cnt = first ? rdat[1:0] : cnt + 2'h1;
        first = 0;
        chk("odd", rdat[15:8], od);
        chk("even", {rdat[7:2], 2'b0}, evn);
        chk("counter", rdat[1:0], cnt);
        exp_q.push_front({od, evn | cnt});
    endtask

    task t_regs;
        apb(ADDR_CTRL, 1'b0, 32'h0);
        chk("ctrl reset", rdat, CTRL_RESET);
        apb(ADDR_THRESH, 1'b0, 32'h0);
        chk("thresh reset", rdat, THRESH_RESET);
        apb(ADDR_THRESH, 1'b1, 32'h0140_0064);
        apb(ADDR_THRESH, 1'b0, 32'h0);
        chk("thresh", rdat, 32'h0140_0064);
        apb(8'h40, 1'b0, 32'h0);
        chk("unmapped err", rerr, 1'b1);
        chk("unmapped data", rdat, 32'h0);
    endtask

    task t_modes;
        int tbl[7] = '{1, 2, 100, 101, 319, 320, 0};
        foreach (tbl[i]) second(tbl[i], tbl[i], 1'b0);
        sf <= 1'b1;
        for (int n = 1; n <= 4; n++) second(n, n, 1'b0);
        apb(ADDR_CTRL, 1'b1, 32'h5);
        second(7, 7, 1'b1);
        second(8, 8, 1'b1);
    endtask

    // Link held by customer traffic, then the frame is decoded
    task t_frame;
        int k;
        logic [15:0] pr;
        hold <= 1'b1;
        repeat (4) @(posedge pclk);
        while (dl_drive === 1'b1) @(posedge pclk);
        repeat (40) @(posedge pclk);
        second(5, 0, 1'b1);
        k = nframes;
        repeat (400) @(posedge pclk);
        chk("frame held", nframes, k);
        hold <= 1'b0;
        while (nframes == k) @(posedge pclk);
        chk("header", frame[23:0], 24'h03_01_42);
        for (int j = 0; j < 4; j++) begin
            pr = {exp_q[j][7:0], exp_q[j][15:8]};
            chk("pair", frame[24 + 16 * j +: 16], pr);
        end
        chk("fcs", residue(frame), 16'hF0B8);
    endtask

    task t_cust;
        apb(ADDR_CTRL, 1'b1, 32'h6);
        ccnt <= 2'h2;
        cdone <= 1'b1;
        @(posedge pclk);
        cdone <= 1'b0;
        tick <= 1'b1;
        @(posedge pclk);
        tick <= 1'b0;
        apb(ADDR_REPORT, 1'b0, 32'h0);
        chk("copied count", rdat[1:0], 2'h2);
    endtask

    // Whole run is a few thousand cycles; the ceiling leaves ample margin
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            summarize;
        end
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_modes;
        t_frame;
        t_cust;
        summarize;
    end
endmodule
`default_nettype wire
